// ==== shared/cou_pkg.sv ====
// Package: register map, field positions and codes for the output unit control
package cou_pkg;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL0     = 4'h0;
    localparam logic [3:0] ADDR_CTRL1     = 4'h1;
    localparam logic [3:0] ADDR_SHDN0     = 4'h2;
    localparam logic [3:0] ADDR_SHDN_SRC  = 4'h3;
    localparam logic [3:0] ADDR_RISE_DB   = 4'h4;
    localparam logic [3:0] ADDR_FALL_DB   = 4'h5;
    localparam logic [3:0] ADDR_RISE_BLK  = 4'h6;
    localparam logic [3:0] ADDR_FALL_BLK  = 4'h7;
    localparam logic [3:0] ADDR_RISE_PH   = 4'h8;
    localparam logic [3:0] ADDR_FALL_PH   = 4'h9;
    localparam logic [3:0] ADDR_STATUS    = 4'hA;
    localparam int         NUM_COUNTS     = 6;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL0_EN_BIT   = 7;
    localparam int CTRL0_LD_BIT   = 6;
    localparam int CTRL1_RISE_DEADBAND_SOURCE_BIT = 7;
    localparam int CTRL1_FALL_DEADBAND_SOURCE_BIT = 6;
    localparam int SHDN0_ASE_BIT  = 7;
    localparam int SHDN0_ARS_BIT  = 6;
    // Writable masks; unimplemented bits read zero
    localparam logic [7:0] CTRL0_MASK  = 8'h1F;
    localparam logic [7:0] CTRL1_MASK  = 8'hCF;
    localparam logic [7:0] SHDN0_MASK  = 8'hFF;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // ----------------------------------------
    // Clock select and override codes
    // ----------------------------------------
    localparam logic [1:0] CLK_DIV4    = 2'h0;
    localparam logic [1:0] CLK_SYS     = 2'h1;
    localparam logic [1:0] CLK_FASTOSC = 2'h2;
    localparam logic [1:0] OVR_INACTIVE = 2'h0;
    localparam logic [1:0] OVR_TRISTATE = 2'h1;
    localparam logic [1:0] OVR_LOW      = 2'h2;
    localparam logic [1:0] OVR_HIGH     = 2'h3;
    localparam logic [1:0] PRESCALE_MAX = 2'h3;
endpackage

// ==== verilog/cou_control.sv ====
// Control, restart and buffer-load logic of the complementary output unit
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`default_nettype none
module cou_control
    import cou_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rd_data,
    input  wire logic        pin_in,
    input  wire logic [6:0]  fault_src,
    input  wire logic        rise_evt_in,
    input  wire logic        fall_evt_in,
    input  wire logic        pin_as_rise,
    input  wire logic        pin_as_fall,
    input  wire logic        fast_osc_clk_unused,
    output logic             enabled,
    output logic      [2:0]  output_mode_field,
    output logic      [1:0]  clock_select,
    output logic             gen_clk_tick,
    output logic             fast_osc_keep_on,
    output logic             rise_deadband_source,
    output logic             fall_deadband_source,
    output logic      [3:0]  drive_out,
    output logic      [3:0]  drive_oe,
    output logic      [7:0]  work_rise_db,
    output logic      [7:0]  work_fall_db,
    output logic      [7:0]  work_rise_blk,
    output logic      [7:0]  work_fall_blk,
    output logic      [7:0]  work_rise_ph,
    output logic      [7:0]  work_fall_ph
);
    // ----------------------------------------
    // Synchronisers for asynchronous inputs
    // ----------------------------------------
    // Pin, fault and event inputs arrive from other logic or pins with
    // no relation to core_clk, so all of them share one two-stage chain.
    // Only the second stage is read; the first may be metastable.
    // Cost: every event and fault is seen two cycles late.
    logic [9:0] sync_a;
    logic [9:0] sync_b;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_a <= 10'h000;
            sync_b <= 10'h000;
        end else begin
            sync_a <= {fall_evt_in, rise_evt_in, fault_src, pin_in};
            sync_b <= sync_a;
        end
    end
    logic       pin_s;
    logic [6:0] fault_s;
    logic       rise_s;
    logic       fall_s;
    assign pin_s   = sync_b[0];
    assign fault_s = sync_b[7:1];
    assign rise_s  = sync_b[8] | (pin_as_rise & pin_s);
    assign fall_s  = sync_b[9] | (pin_as_fall & pin_s);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] shdn0;
    logic [7:0] shdn_src;
    logic [7:0] count_reg [NUM_COUNTS];
    logic [7:0] work_buf  [NUM_COUNTS];
    logic       en_bit;
    logic       ld_bit;
    logic       shutdown_active;
    logic       auto_restart_select;
    logic       fault_any;
    logic       rise_prev;
    logic       rise_edge;
    logic       fall_prev;
    logic       evt_edge;
    logic       running;

    assign en_bit = ctrl0[CTRL0_EN_BIT];
    assign ld_bit = ctrl0[CTRL0_LD_BIT];
    assign shutdown_active    = shdn0[SHDN0_ASE_BIT];
    assign auto_restart_select  = shdn0[SHDN0_ARS_BIT];
    // Bit 0 of the source register selects the pin; the rest the other sources
    // Sources are active low; a selected source held low keeps shutdown
    // asserted every cycle, which is what makes the condition level based
    assign fault_any = |(shdn_src & ~{fault_s, pin_s});
    assign rise_edge = rise_s & ~rise_prev;
    assign evt_edge  = rise_edge | (fall_s & ~fall_prev);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rise_prev <= 1'b0;
            fall_prev <= 1'b0;
        end else begin
            rise_prev <= rise_s;
            fall_prev <= fall_s;
        end
    end

    logic ctrl0_wr;
    assign ctrl0_wr = wr_en && addr == ADDR_CTRL0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl0 <= RESET_VALUE;
        end else if (ctrl0_wr) begin
            // Load bit written one; a zero write cannot abort a pending load
            ctrl0 <= {wr_data[CTRL0_EN_BIT], wr_data[CTRL0_LD_BIT] | ld_bit, 1'b0,
                      wr_data[4:0] & CTRL0_MASK[4:0]};
        end else if (ld_bit && (evt_edge || !en_bit)) begin
            ctrl0[CTRL0_LD_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl1 <= RESET_VALUE;
        end else if (wr_en && addr == ADDR_CTRL1) begin
            ctrl1 <= wr_data & CTRL1_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            shdn_src <= RESET_VALUE;
        end else if (wr_en && addr == ADDR_SHDN_SRC) begin
            shdn_src <= wr_data;
        end
    end

    // Shutdown-active: hardware set wins over software clear
    // Priority order: fault or software set, then software clear, then
    // auto-clear. A clear that meets an active fault is simply lost;
    // software must read the bit back to know it took effect.
    logic sw_clear;
    logic sw_set;
    assign sw_set   = wr_en && addr == ADDR_SHDN0 && wr_data[SHDN0_ASE_BIT];
    assign sw_clear = wr_en && addr == ADDR_SHDN0 && !wr_data[SHDN0_ASE_BIT];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shdn0 <= RESET_VALUE;
        end else begin
            if (wr_en && addr == ADDR_SHDN0) begin
                shdn0[5:0]           <= wr_data[5:0];
                shdn0[SHDN0_ARS_BIT] <= wr_data[SHDN0_ARS_BIT];
            end
            if (fault_any || sw_set) begin
                shdn0[SHDN0_ASE_BIT] <= 1'b1;
            end else if (sw_clear) begin
                shdn0[SHDN0_ASE_BIT] <= 1'b0;
            end else if (auto_restart_select && shutdown_active) begin
                shdn0[SHDN0_ASE_BIT] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Count registers and working buffers
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_COUNTS; gi++) begin : g_count
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    count_reg[gi] <= RESET_VALUE;
                end else if (wr_en && addr == ADDR_RISE_DB + 4'(gi)) begin
                    count_reg[gi] <= wr_data;
                end
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    work_buf[gi] <= RESET_VALUE;
                end else if (!en_bit && wr_en && addr == ADDR_RISE_DB + 4'(gi)) begin
                    work_buf[gi] <= wr_data;
                end else if (!en_bit) begin
                    work_buf[gi] <= count_reg[gi];
                end else if (ld_bit && evt_edge) begin
                    work_buf[gi] <= count_reg[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Run state: starts in shutdown, resumes on rising event
    // ----------------------------------------
    // Cleared by disable as well, so every enable begins from the
    // override levels until the first rising edge after shutdown ends.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            running <= 1'b0;
        end else if (!en_bit || shutdown_active || fault_any) begin
            running <= 1'b0;
        end else if (rise_edge) begin
            running <= 1'b1;
        end
    end

    // Generator clock tick: divide-by-four prescale for the divided setting
    logic [1:0] prescale;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prescale <= 2'h0;
        end else begin
            prescale <= prescale + 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            gen_clk_tick     <= 1'b0;
            fast_osc_keep_on <= 1'b0;
        end else begin
            gen_clk_tick     <= (ctrl0[4:3] == CLK_DIV4) ? (prescale == PRESCALE_MAX)
                                                         : (ctrl0[4:3] != 2'h3);
            fast_osc_keep_on <= en_bit && ctrl0[4:3] == CLK_FASTOSC;
        end
    end

    // ----------------------------------------
    // Output drive: pass-through active state or overrides
    // ----------------------------------------
    // Limitation: the active state is a stand-in for the steering path;
    // A and C follow the rising input, B and D its inverse.
    logic [3:0] next_drive_out;
    logic [3:0] next_drive_oe;
    always_comb begin
        logic [1:0] ovr;
        ovr            = 2'h0;
        next_drive_out = 4'h0;
        next_drive_oe  = 4'h0;
        for (int i = 0; i < 4; i++) begin
            ovr = (i == 0 || i == 2) ? shdn0[3:2] : shdn0[1:0];
            if (!en_bit) begin
                next_drive_out[i] = 1'b0;
                next_drive_oe[i]  = 1'b0;
            end else if (running) begin
                next_drive_oe[i]  = 1'b1;
                next_drive_out[i] = (rise_s ^ i[0]) ^ ctrl1[i];
            end else begin
                next_drive_oe[i] = 1'b1;
                case (ovr)
                    OVR_LOW:      next_drive_out[i] = 1'b0;
                    OVR_HIGH:     next_drive_out[i] = 1'b1;
                    OVR_TRISTATE: next_drive_oe[i]  = 1'b0;
                    default:      next_drive_out[i] = ctrl1[i];
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_out <= 4'h0;
            drive_oe  <= 4'h0;
        end else begin
            drive_out <= next_drive_out;
            drive_oe  <= next_drive_oe;
        end
    end

    // ----------------------------------------
    // Registered configuration outputs
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enabled              <= 1'b0;
            output_mode_field    <= 3'h0;
            clock_select         <= 2'h0;
            rise_deadband_source <= 1'b0;
            fall_deadband_source <= 1'b0;
            work_rise_db         <= 8'h00;
            work_fall_db         <= 8'h00;
            work_rise_blk        <= 8'h00;
            work_fall_blk        <= 8'h00;
            work_rise_ph         <= 8'h00;
            work_fall_ph         <= 8'h00;
        end else begin
            enabled              <= en_bit;
            output_mode_field    <= ctrl0[2:0];
            clock_select         <= ctrl0[4:3];
            rise_deadband_source <= ctrl1[CTRL1_RISE_DEADBAND_SOURCE_BIT];
            fall_deadband_source <= ctrl1[CTRL1_FALL_DEADBAND_SOURCE_BIT];
            work_rise_db         <= work_buf[0];
            work_fall_db         <= work_buf[1];
            work_rise_blk        <= work_buf[2];
            work_fall_blk        <= work_buf[3];
            work_rise_ph         <= work_buf[4];
            work_fall_ph         <= work_buf[5];
        end
    end

    // ----------------------------------------
    // Read port: data in the cycle after the strobe
    // ----------------------------------------
    // Zero outside the read cycle so a stale value is never mistaken
    // for a fresh answer by a master that samples late.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                ADDR_CTRL0:    rd_data <= ctrl0;
                ADDR_CTRL1:    rd_data <= ctrl1;
                ADDR_SHDN0:    rd_data <= shdn0;
                ADDR_SHDN_SRC: rd_data <= shdn_src;
                ADDR_RISE_DB,  ADDR_FALL_DB,  ADDR_RISE_BLK,
                ADDR_FALL_BLK, ADDR_RISE_PH,  ADDR_FALL_PH:
                    rd_data <= count_reg[3'(addr - ADDR_RISE_DB)];
                ADDR_STATUS:   rd_data <= {6'h00, fault_any, running};
                default:       rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ==== tb/cou_control_properties.sv ====
// Checker: port-level properties of the output unit control
`default_nettype none
module cou_control_props
    import cou_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    input wire logic       enabled,
    input wire logic [2:0] output_mode_field,
    input wire logic [1:0] clock_select,
    input wire logic       gen_clk_tick,
    input wire logic       fast_osc_keep_on,
    input wire logic       rise_deadband_source,
    input wire logic       fall_deadband_source
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic wr0;
    logic wr1;
    assign wr0 = wr_en && addr == ADDR_CTRL0;
    assign wr1 = wr_en && addr == ADDR_CTRL1;
    ctrl0_spare_zero_a: assert property (
        $past(rd_en) && $past(addr) == ADDR_CTRL0 |-> rd_data[5] == 1'b0)
        else $error("control zero bit 5 reads one");
    ctrl1_spare_zero_a: assert property (
        $past(rd_en) && $past(addr) == ADDR_CTRL1 |-> rd_data[5:4] == 2'h0)
        else $error("control one bits 5-4 read nonzero");
    enable_follows_a: assert property (
        wr0 |-> ##2 enabled == $past(wr_data[CTRL0_EN_BIT], 2))
        else $error("enable does not follow write");
    clock_field_a: assert property (
        wr0 |-> ##2 clock_select == $past(wr_data[4:3], 2))
        else $error("clock select does not follow write");
    mode_field_a: assert property (
        wr0 |-> ##2 output_mode_field == $past(wr_data[2:0], 2))
        else $error("mode field does not follow write");
    rise_db_src_a: assert property (
        wr1 |-> ##2 rise_deadband_source == $past(wr_data[CTRL1_RISE_DEADBAND_SOURCE_BIT], 2))
        else $error("rising dead-band source wrong");
    fall_db_src_a: assert property (
        wr1 |-> ##2 fall_deadband_source == $past(wr_data[CTRL1_FALL_DEADBAND_SOURCE_BIT], 2))
        else $error("falling dead-band source wrong");
    keep_osc_on_a: assert property (
        (enabled && clock_select == CLK_FASTOSC)[*2] |-> fast_osc_keep_on)
        else $error("oscillator not held on");
    osc_release_a: assert property (
        (!enabled)[*2] |-> !fast_osc_keep_on)
        else $error("oscillator held while disabled");
    sys_tick_a: assert property (
        (clock_select == CLK_SYS)[*2] |-> gen_clk_tick)
        else $error("system clock tick missing");
    div4_tick_a: assert property (
        (clock_select == CLK_DIV4)[*5] |-> $countones({gen_clk_tick,
        $past(gen_clk_tick), $past(gen_clk_tick, 2), $past(gen_clk_tick, 3)}) == 1)
        else $error("divided tick not one in four");
endmodule
`default_nettype wire

// ==== tb/cou_switch_model.sv ====
// Partner model: power stage gate inputs fed by the unit outputs
`default_nettype none
module cou_switch_model (
    input  wire logic [3:0] drive_out,
    input  wire logic [3:0] drive_oe,
    output logic      [3:0] gate
);
    timeunit 1ns;
    timeprecision 1ps;
    // Gate pull-down holds a released switch off, never floating
    assign gate = drive_out & drive_oe;
endmodule
`default_nettype wire

// ==== tb/cou_control_tb.sv ====
// Testbench: self-checking scenarios for the output unit control
`default_nettype none
module cou_control_tb
    import cou_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0;
    logic       rst, wr_en, rd_en, pin_in, rise_evt_in, pin_as_rise, pin_as_fall;
    logic [3:0] addr, drive_out, drive_oe, gate;
    logic [7:0] wr_data, rd_data;
    logic [6:0] fault_src;
    logic [7:0] w0, w1, w2, w3, w4, w5;
    int         fails = 0;
    int         tests_run = 0;
    wire  [47:0] work_all = {w5, w4, w3, w2, w1, w0};
    always #10 core_clk = ~core_clk;
    cou_control uut (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in), .fault_src(fault_src),
        .rise_evt_in(rise_evt_in), .fall_evt_in(1'b0), .pin_as_rise(pin_as_rise),
        .pin_as_fall(pin_as_fall), .fast_osc_clk_unused(1'b0), .enabled(),
        .output_mode_field(), .clock_select(), .gen_clk_tick(), .fast_osc_keep_on(),
        .rise_deadband_source(), .fall_deadband_source(), .drive_out(drive_out),
        .drive_oe(drive_oe), .work_rise_db(w0), .work_fall_db(w1), .work_rise_blk(w2),
        .work_fall_blk(w3), .work_rise_ph(w4), .work_fall_ph(w5));
    cou_switch_model sw (.drive_out(drive_out), .drive_oe(drive_oe), .gate(gate));
    // ------
    // Bus and compare tasks
    // ------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
    endtask
    // Pin or rising input high long enough to pass the synchronisers
    task automatic pulse(input logic use_pin);
        @(posedge core_clk);
        if (use_pin) begin
            pin_in <= 1'b1;
        end else begin
            rise_evt_in <= 1'b1;
        end
        repeat (3) @(posedge core_clk);
        pin_in <= 1'b0;
        rise_evt_in <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic end_of_test();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_regs();
        chk_rd(ADDR_CTRL0, 8'h00);
        chk_rd(ADDR_CTRL1, 8'h00);
        wr(ADDR_CTRL1, 8'hFF);
        chk_rd(ADDR_CTRL1, 8'hCF);
        wr(ADDR_CTRL0, 8'h7F);
        repeat (2) @(posedge core_clk);
        chk_rd(ADDR_CTRL0, 8'h1F);
        wr(4'hF, 8'hFF);
        chk_rd(4'hF, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_fields();
        for (int m = 0; m < 6; m++) begin
            wr(ADDR_CTRL0, {3'h0, 2'(m % 3), 3'(m)});
            repeat (6) @(posedge core_clk);
            chk({3'h0, uut.clock_select, uut.output_mode_field}, {3'h0, 2'(m % 3), 3'(m)});
        end
        wr(ADDR_CTRL0, 8'h90);
        repeat (3) @(posedge core_clk);
        chk({7'h0, uut.fast_osc_keep_on}, 8'h01);
        wr(ADDR_CTRL0, 8'h00);
        $display("t_fields done");
    endtask
    task automatic t_buf();
        for (int i = 0; i < NUM_COUNTS; i++) begin
            wr(ADDR_RISE_DB + 4'(i), 8'h11 * 8'(i + 1));
        end
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < NUM_COUNTS; i++) begin
            chk(work_all[i*8 +: 8], 8'h11 * 8'(i + 1));
        end
        wr(ADDR_CTRL0, 8'h80);
        for (int i = 0; i < NUM_COUNTS; i++) begin
            wr(ADDR_RISE_DB + 4'(i), 8'hA0 + 8'(i));
        end
        repeat (3) @(posedge core_clk);
        chk(work_all[7:0], 8'h11);
        wr(ADDR_CTRL0, 8'hC0);
        chk_rd(ADDR_CTRL0, 8'hC0);
        pin_as_fall <= 1'b1;
        pulse(1'b1);
        pin_as_fall <= 1'b0;
        chk_rd(ADDR_CTRL0, 8'h80);
        for (int i = 0; i < NUM_COUNTS; i++) begin
            chk(work_all[i*8 +: 8], 8'hA0 + 8'(i));
        end
        wr(ADDR_CTRL0, 8'h00);
        $display("t_buf done");
    endtask
    task automatic t_shdn();
        wr(ADDR_SHDN0, 8'h8B);
        wr(ADDR_SHDN_SRC, 8'h02);
        wr(ADDR_CTRL0, 8'h80);
        repeat (3) @(posedge core_clk);
        chk_rd(ADDR_STATUS, 8'h00);
        chk({drive_oe, gate}, 8'hFA);
        fault_src[0] <= 1'b0;
        repeat (4) @(posedge core_clk);
        wr(ADDR_SHDN0, 8'h0B);
        chk_rd(ADDR_SHDN0, 8'h8B);
        chk_rd(ADDR_STATUS, 8'h02);
        fault_src[0] <= 1'b1;
        pulse(1'b0);
        chk_rd(ADDR_STATUS, 8'h00);
        wr(ADDR_SHDN0, 8'h0B);
        repeat (4) @(posedge core_clk);
        chk_rd(ADDR_STATUS, 8'h00);
        pulse(1'b0);
        chk_rd(ADDR_STATUS, 8'h01);
        wr(ADDR_SHDN0, 8'h85);
        repeat (2) @(posedge core_clk);
        #1 chk({drive_oe, gate}, 8'h00);
        $display("t_shdn done");
    endtask
    task automatic t_auto();
        wr(ADDR_SHDN_SRC, 8'h01);
        wr(ADDR_SHDN0, 8'hCB);
        chk_rd(ADDR_SHDN0, 8'hCB);
        pin_in <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk_rd(ADDR_SHDN0, 8'h4B);
        chk_rd(ADDR_STATUS, 8'h00);
        wr(ADDR_SHDN_SRC, 8'h00);
        // Pin must settle low before routing, else the route itself is an edge
        pin_in <= 1'b0;
        repeat (4) @(posedge core_clk);
        pin_as_rise <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk_rd(ADDR_STATUS, 8'h00);
        pulse(1'b1);
        chk_rd(ADDR_STATUS, 8'h01);
        $display("t_auto done");
    endtask
    initial begin
        {rst, wr_en, rd_en, pin_in, rise_evt_in, pin_as_rise, pin_as_fall} = 7'h40;
        {addr, wr_data, fault_src} = {4'h0, 8'h00, 7'h7F};
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_fields();
        t_buf();
        t_shdn();
        t_auto();
        end_of_test();
    end
    // Generous over the few hundred cycles the scenarios need
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        end_of_test();
    end
endmodule
bind cou_control cou_control_props props_i (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .enabled(enabled), .clock_select(clock_select),
    .output_mode_field(output_mode_field), .gen_clk_tick(gen_clk_tick),
    .fast_osc_keep_on(fast_osc_keep_on), .rise_deadband_source(rise_deadband_source),
    .fall_deadband_source(fall_deadband_source));
`default_nettype wire
